// ===== rtl/eeprom_pkg.sv
package eeprom_pkg;

  // opcodes
  localparam logic [7:0] OP_ARM_WRITE    = 8'h06;
  localparam logic [7:0] OP_DISARM_WRITE = 8'h04;
  localparam logic [7:0] OP_STATE_READ   = 8'h05;
  localparam logic [7:0] OP_STATE_WRITE  = 8'h01;
  localparam logic [7:0] OP_ARRAY_READ   = 8'h03;
  localparam logic [7:0] OP_ARRAY_WRITE  = 8'h02;
  localparam logic [7:0] OP_X_MASK       = 8'hF7;
  localparam int         OP_X_BIT        = 3;

  // device_state_reg layout
  localparam logic [3:0] STATE_HI_ONES   = 4'hF;
  localparam int         SR_PROT_HI      = 3;
  localparam int         SR_PROT_LO      = 2;
  localparam logic [1:0] PROT_RESET      = 2'h0;

  // organisation
  localparam int         MEM_BYTES_DEF   = 512;
  localparam int         PAGE_BYTES      = 16;

  // timing
  localparam int         CORE_CLK_KHZ    = 10000;
  localparam int         PROG_TIME_US    = 5000;
  localparam int         PROG_CYCLES     = PROG_TIME_US * CORE_CLK_KHZ / 1000;

  typedef enum logic [2:0] {
    S_IDLE     = 3'h0,
    S_OPCODE   = 3'h1,
    S_ADDR     = 3'h3,
    S_RD_DATA  = 3'h2,
    S_WR_DATA  = 3'h6,
    S_SR_READ  = 3'h7,
    S_SR_WRITE = 3'h5,
    S_IGNORE   = 3'h4
  } seq_state_t;

endpackage

// ===== rtl/pin_sync.sv
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  // pins
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_ff;

  // first stage feeds only the second
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      meta_ff <= '0;
      o_q     <= '0;
    end
    else
    begin
      meta_ff <= i_d;
      o_q     <= meta_ff;
    end
  end
endmodule // pin_sync

// ===== rtl/prog_timer.sv
`timescale 1ns/100ps
module prog_timer #(
  parameter int CYCLES = eeprom_pkg::PROG_CYCLES
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // control
  input  wire logic i_start,
  output logic      o_busy,
  output logic      o_done
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_ff;
  wire           last = (cnt_ff == CW'(CYCLES - 1));

  if (CYCLES < 2)
  begin : g_bad_cycles
    $error("prog_timer needs at least two cycles");
  end

  // once begun, nothing but reset stops the count
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt_ff <= '0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end
    else
    begin
      o_done <= o_busy & last;
      if (i_start & ~o_busy)
      begin
        o_busy <= 1'b1;
        cnt_ff <= '0;
      end
      else if (o_busy)
      begin
        o_busy <= ~last;
        cnt_ff <= cnt_ff + CW'(1);
      end
    end
  end
endmodule // prog_timer

// ===== rtl/spi_eeprom_command_slave.sv
`timescale 1ns/100ps
module spi_eeprom_command_slave #(
  parameter int MEM_BYTES   = eeprom_pkg::MEM_BYTES_DEF,
  parameter int PROG_CYCLES = eeprom_pkg::PROG_CYCLES
) (
  // clock and reset
  input  wire logic I_CORE_CLK,
  input  wire logic I_RST,
  // serial link
  input  wire logic I_CS_N,
  input  wire logic I_SCK,
  input  wire logic I_SI,
  input  wire logic I_WP_N,
  input  wire logic I_HOLD_N,
  output logic      O_SO,
  output logic      O_SO_OE
);
  import eeprom_pkg::*;

  localparam int AW = $clog2(MEM_BYTES);
  localparam int PW = $clog2(PAGE_BYTES);

  if (MEM_BYTES != 128 && MEM_BYTES != 256 && MEM_BYTES != 512)
  begin : g_bad_size
    $error("MEM_BYTES must be 128, 256 or 512");
  end

  // X bit is only an address bit on the largest variant
  function automatic logic op_is(input logic [7:0] b, input logic [7:0] op);
    logic [7:0] m;
    m     = (AW == 9) ? OP_X_MASK : 8'hFF;
    op_is = ((b & m) == op);
  endfunction

  function automatic logic prot_hit(input logic [AW-1:0] a,
                                    input logic [1:0]    lvl);
    logic hit;
    hit = 1'b0;
    unique case (lvl)
      2'h0: hit = 1'b0;
      2'h1: hit = a[AW-1] & a[AW-2];
      2'h2: hit = a[AW-1];
      2'h3: hit = 1'b1;
    endcase
    return hit;
  endfunction

  logic [4:0]      pins_s;
  logic            cs_d_ff;
  logic            sck_d_ff;
  seq_state_t      st_ff;
  seq_state_t      nxt_st;
  seq_state_t      op_next;
  logic [2:0]      bit_cnt_ff;
  logic [7:0]      sh_ff;
  logic [7:0]      out_sh_ff;
  logic            started_ff;
  logic            armed_ff;
  logic            nxt_armed;
  logic [1:0]      prot_ff;
  logic [1:0]      sr_new_ff;
  logic            sr_done_ff;
  logic            wr_seq_ff;
  logic            op_x_ff;
  logic            abandon_ff;
  logic [AW-1:0]   addr_ff;
  logic [PAGE_BYTES-1:0] wmask_ff;
  logic [7:0]      mem   [MEM_BYTES];
  logic [7:0]      pbuf  [PAGE_BYTES];
  logic            busy;
  logic            prog_done;

  pin_sync #(
    .W (5)
  ) u_sync (
    .i_clk (I_CORE_CLK),
    .i_rst (I_RST),
    .i_d   ({I_CS_N, I_SCK, I_SI, I_WP_N, I_HOLD_N}),
    .o_q   (pins_s)
  );

  wire cs_s     = pins_s[4];
  wire sck_s    = pins_s[3];
  wire si_s     = pins_s[2];
  wire wp_s     = pins_s[1];
  wire hold_s   = pins_s[0];

  // clock edges are seen only while selected and not paused
  wire active   = ~cs_s & hold_s;
  wire sck_rise = active & sck_s & ~sck_d_ff;
  wire sck_fall = active & ~sck_s & sck_d_ff;
  wire cs_rise  = cs_s & ~cs_d_ff;
  wire cs_fall  = ~cs_s & cs_d_ff;
  wire counting = sck_rise & (st_ff != S_IDLE);
  wire byte_done = counting & (bit_cnt_ff == 3'h7);
  wire [7:0] rx_byte = {sh_ff[6:0], si_s};
  wire op_done  = byte_done & (st_ff == S_OPCODE);

  wire is_arm    = (rx_byte == OP_ARM_WRITE);
  wire is_disarm = (rx_byte == OP_DISARM_WRITE);
  wire is_sr_rd  = (rx_byte == OP_STATE_READ);
  wire is_sr_wr  = (rx_byte == OP_STATE_WRITE);
  wire is_rd     = op_is(rx_byte, OP_ARRAY_READ);
  wire is_wr     = op_is(rx_byte, OP_ARRAY_WRITE);

  wire [AW-1:0] addr_in  = AW'({op_x_ff, rx_byte});
  wire [AW-1:0] addr_inc = addr_ff + AW'(1);
  wire [PW-1:0] page_idx = addr_ff[PW-1:0];
  wire          in_prot  = prot_hit(addr_in, prot_ff);
  wire          reading  = (st_ff == S_RD_DATA) | (st_ff == S_SR_READ);
  wire          rd_fall  = sck_fall & reading;
  wire [7:0]    state_val = {STATE_HI_ONES, prot_ff, armed_ff, busy};

  // a write counts only if it ended on a byte boundary
  wire prog_arr = (st_ff == S_WR_DATA) & (|wmask_ff);
  wire prog_sr  = sr_done_ff;
  wire prog_start = cs_rise & ~busy & ~abandon_ff & wp_s &
                    (bit_cnt_ff == 3'h0) & (prog_arr | prog_sr);

  // busy blocks everything except the state read
  assign op_next = busy ? (is_sr_rd ? S_SR_READ : S_IGNORE) :
                   is_sr_rd ? S_SR_READ :
                   is_sr_wr ? (armed_ff ? S_SR_WRITE : S_IGNORE) :
                   is_rd    ? S_ADDR :
                   is_wr    ? (armed_ff ? S_ADDR : S_IGNORE) :
                   S_IGNORE;

  always_comb
  begin
    nxt_st = st_ff;
    if (cs_s)
      nxt_st = S_IDLE;
    else if (st_ff == S_IDLE)
    begin
      if (cs_fall)
        nxt_st = S_OPCODE;
    end
    else if (byte_done)
    begin
      unique case (st_ff)
        S_OPCODE:   nxt_st = op_next;
        S_ADDR:     nxt_st = ~wr_seq_ff ? S_RD_DATA :
                             in_prot    ? S_IGNORE : S_WR_DATA;
        S_SR_WRITE: nxt_st = S_IGNORE;
        S_IDLE, S_RD_DATA, S_WR_DATA, S_SR_READ, S_IGNORE:
                    nxt_st = st_ff;
      endcase
    end
  end

  // guard low holds the latch clear; completion disarms
  always_comb
  begin
    nxt_armed = armed_ff;
    if (op_done & ~busy & is_arm)
      nxt_armed = 1'b1;
    if (op_done & ~busy & is_disarm)
      nxt_armed = 1'b0;
    if (prog_done | ~wp_s)
      nxt_armed = 1'b0;
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      cs_d_ff  <= 1'b0;
      sck_d_ff <= 1'b0;
      st_ff    <= S_IDLE;
      armed_ff <= 1'b0;
      prot_ff  <= PROT_RESET;
    end
    else
    begin
      cs_d_ff  <= cs_s;
      sck_d_ff <= sck_s;
      st_ff    <= nxt_st;
      armed_ff <= nxt_armed;
      if (prog_start & prog_sr)
        prot_ff <= sr_new_ff;
    end
  end

  // position in the sequence moves on counted edges and clears while deselected
  always_ff @(posedge I_CORE_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      bit_cnt_ff <= 3'h0;
      sh_ff      <= 8'h00;
    end
    else if (cs_s)
      bit_cnt_ff <= 3'h0;
    else if (counting)
    begin
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
      sh_ff      <= rx_byte;
    end
  end

  // per-frame write bookkeeping
  always_ff @(posedge I_CORE_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      wr_seq_ff  <= 1'b0;
      op_x_ff    <= 1'b0;
      sr_done_ff <= 1'b0;
      sr_new_ff  <= PROT_RESET;
      abandon_ff <= 1'b0;
      wmask_ff   <= '0;
    end
    else
    begin
      abandon_ff <= (abandon_ff & ~cs_fall) | (~wp_s & ~cs_s);
      if (cs_fall | cs_rise)
      begin
        sr_done_ff <= 1'b0;
        wmask_ff   <= '0;
      end
      else if (byte_done & (st_ff == S_SR_WRITE))
      begin
        sr_done_ff <= 1'b1;
        sr_new_ff  <= rx_byte[SR_PROT_HI:SR_PROT_LO];
      end
      else if (byte_done & (st_ff == S_WR_DATA))
        wmask_ff[page_idx] <= 1'b1;
      if (op_done)
      begin
        wr_seq_ff <= is_wr;
        op_x_ff   <= rx_byte[OP_X_BIT];
      end
    end
  end

  // address pointer: full wrap on read, page wrap on write
  always_ff @(posedge I_CORE_CLK or posedge I_RST)
  begin
    if (I_RST)
      addr_ff <= '0;
    else if (byte_done)
    begin
      if (st_ff == S_ADDR)
        addr_ff <= addr_in;
      else if (st_ff == S_RD_DATA)
        addr_ff <= addr_inc;
      else if (st_ff == S_WR_DATA)
        addr_ff <= {addr_ff[AW-1:PW], page_idx + PW'(1)};
    end
  end

  // array and page buffer; the bytes written in the frame land at once when programming starts
  always_ff @(posedge I_CORE_CLK)
  begin
    if (byte_done & (st_ff == S_WR_DATA))
      pbuf[page_idx] <= rx_byte;
    if (prog_start & prog_arr)
      for (int i = 0; i < PAGE_BYTES; i++)
        if (wmask_ff[i])
          mem[{addr_ff[AW-1:PW], PW'(i)}] <= pbuf[i];
  end

  prog_timer #(
    .CYCLES (PROG_CYCLES)
  ) u_timer (
    .i_clk   (I_CORE_CLK),
    .i_rst   (I_RST),
    .i_start (prog_start),
    .o_busy  (busy),
    .o_done  (prog_done)
  );

  // output path: reload at byte end, shift on falling edges
  always_ff @(posedge I_CORE_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      out_sh_ff  <= 8'h00;
      O_SO       <= 1'b0;
      O_SO_OE    <= 1'b0;
      started_ff <= 1'b0;
    end
    else
    begin
      if (byte_done & (st_ff == S_ADDR) & ~wr_seq_ff)
        out_sh_ff <= mem[addr_in];
      else if (byte_done & (st_ff == S_RD_DATA))
        out_sh_ff <= mem[addr_inc];
      else if (op_done | (byte_done & (st_ff == S_SR_READ)))
        out_sh_ff <= state_val;
      else if (rd_fall)
        out_sh_ff <= {out_sh_ff[6:0], 1'b0};
      if (rd_fall)
        O_SO <= out_sh_ff[7];
      started_ff <= ~cs_s & (started_ff | rd_fall);
      // hold drops drive at once but keeps the read position
      O_SO_OE <= active & reading & (started_ff | rd_fall);
    end
  end

  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (I_RST);

  a_so_off_cs: assert property (cs_s |=> !O_SO_OE)
    else $error("output driven while deselected");
  a_so_off_hold: assert property (!hold_s |=> !O_SO_OE)
    else $error("output driven while paused");
  a_pause_pos: assert property (!hold_s && !cs_s |=> $stable(bit_cnt_ff))
    else $error("bit position moved while paused");
  a_need_fall: assert property
    (st_ff == S_IDLE && !cs_fall |=> st_ff == S_IDLE)
    else $error("decoding began without select falling");
  a_prog_edge: assert property
    (prog_start |-> $past(!cs_s) && cs_s && !abandon_ff)
    else $error("programming started off the select rising edge");
  a_prog_len: assert property
    (prog_start |=> busy [*8] ##1 (busy || prog_done))
    else $error("programming cycle cut short");
  a_armed_guard: assert property (!wp_s |=> !armed_ff)
    else $error("armed flag set while guard low");
  a_busy_ignore: assert property
    (op_done && busy && !is_sr_rd |=> st_ff == S_IGNORE)
    else $error("opcode served while busy");
  a_state_load: assert property
    (op_done && !busy && is_sr_rd |=> out_sh_ff == $past(state_val))
    else $error("state register value wrong");
  a_prot_drop: assert property
    (byte_done && st_ff == S_ADDR && wr_seq_ff && in_prot
     |=> st_ff == S_IGNORE ##1 !prog_arr)
    else $error("protected write not dropped");
  a_read_wrap: assert property
    (byte_done && st_ff == S_RD_DATA && &addr_ff |=> addr_ff == '0)
    else $error("read address did not wrap");

  c_page_write: cover property (prog_start && prog_arr && &wmask_ff);
  c_state_write: cover property (prog_start && prog_sr);
  c_read_stream: cover property (byte_done && st_ff == S_RD_DATA);
  c_paused: cover property (!hold_s && !cs_s && reading);

endmodule // spi_eeprom_command_slave

// ===== dv/spi_master_model.sv
`timescale 1ns/100ps
module spi_master_model (
  // core clock
  input  wire logic i_clk,
  // from the device
  input  wire logic i_so,
  input  wire logic i_so_oe,
  // to the device
  output logic      o_cs_n,
  output logic      o_sck,
  output logic      o_si,
  output logic      o_hold_n
);
  logic mode3;
  logic oe_seen;
  logic oe_held;

  initial
  begin
    mode3    = 1'b0;
    o_cs_n   = 1'b1;
    o_sck    = 1'b0;
    o_si     = 1'b0;
    o_hold_n = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // clock stands at the mode's idle level between frames
  task automatic sel();
    o_sck = mode3;
    tick(4);
    o_cs_n  = 1'b0;
    oe_seen = 1'b0;
    oe_held = 1'b0;
    tick(4);
  endtask

  task automatic desel();
    o_sck = mode3;
    tick(4);
    o_cs_n = 1'b1;
    o_si   = ~o_si;
    tick(8);
  endtask

  // 800 ns bit: low half then high half, sampled before the next fall
  task automatic xbyte(input logic [7:0] tx, input int pause_at,
                       output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      o_sck = 1'b0;
      o_si  = tx[i];
      if (i == pause_at)
      begin
        tick(2);
        o_hold_n = 1'b0;
        // clock and data wiggle while paused; they must not count
        for (int k = 0; k < 4; k++)
        begin
          tick(4);
          if (k > 0)
            oe_held = oe_held | i_so_oe;
          o_sck = ~o_sck;
          o_si  = ~o_si;
        end
        tick(4);
        o_si     = tx[i];
        o_hold_n = 1'b1;
      end
      tick(4);
      o_sck = 1'b1;
      tick(4);
      // an undriven line reads inverted so a missing enable shows up
      rx[i]   = i_so_oe ? i_so : ~i_so;
      oe_seen = oe_seen | i_so_oe;
    end
  endtask
endmodule // spi_master_model

// ===== dv/test_spi_eeprom_command_slave.sv
`timescale 1ns/100ps
`define CHK(what, e, got) \
  begin \
    n_compared++; \
    if ((got) !== (e)) \
    begin \
      errors++; \
      $display("MISMATCH %s exp %h got %h", what, e, got); \
    end \
  end
module test_spi_eeprom_command_slave;
  import eeprom_pkg::*;
  // short busy period so polling sees it; one status frame is ~150 clocks
  localparam int PROG  = 400;
  localparam int POLLS = 6;
  logic       core_clk;
  logic       rst;
  logic       wp_n;
  logic       cs_n;
  logic       sck;
  logic       si;
  logic       hold_n;
  logic       so;
  logic       so_oe;
  logic [7:0] rx;
  logic [7:0] e;
  logic [1:0] lvl;
  logic [8:0] bnd [4];
  logic [7:0] q [$];
  int         errors;
  int         n_compared;

  spi_eeprom_command_slave #(
    .MEM_BYTES   (512),
    .PROG_CYCLES (PROG)
  ) u_spi_eeprom_command_slave (
    .I_CORE_CLK (core_clk),
    .I_RST      (rst),
    .I_CS_N     (cs_n),
    .I_SCK      (sck),
    .I_SI       (si),
    .I_WP_N     (wp_n),
    .I_HOLD_N   (hold_n),
    .O_SO       (so),
    .O_SO_OE    (so_oe)
  );

  spi_master_model mst (
    .i_clk    (core_clk),
    .i_so     (so),
    .i_so_oe  (so_oe),
    .o_cs_n   (cs_n),
    .o_sck    (sck),
    .o_si     (si),
    .o_hold_n (hold_n)
  );

  always #50 core_clk = ~core_clk;

  task automatic end_sim();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic cmd(input logic [7:0] op);
    mst.sel();
    mst.xbyte(op, 8, rx);
    mst.desel();
  endtask

  task automatic get_sr(input int p);
    mst.sel();
    mst.xbyte(OP_STATE_READ, 8, rx);
    mst.xbyte(8'h00, p, rx);
    mst.desel();
  endtask

  task automatic sr(input logic [7:0] x, input int p);
    get_sr(p);
    `CHK("state", x, rx)
  endtask

  task automatic wait_ready();
    int k;
    k = 0;
    do
    begin
      get_sr(8);
      k++;
    end while (rx[0] !== 1'b0 && k < POLLS);
    `CHK("ready", {STATE_HI_ONES, lvl, 2'b00}, rx)
  endtask

  task automatic stw(input logic [1:0] v);
    cmd(OP_ARM_WRITE);
    mst.sel();
    mst.xbyte(OP_STATE_WRITE, 8, rx);
    mst.xbyte({4'h0, v, 2'b00}, 8, rx);
    mst.desel();
  endtask

  // always arms first; wpp pulses the guard low after the address
  task automatic wr(input logic [8:0] a, input int n, input logic [7:0] b,
                    input logic wpp);
    logic [7:0] op;
    op = OP_ARRAY_WRITE;
    op[OP_X_BIT] = a[8];
    cmd(OP_ARM_WRITE);
    mst.sel();
    mst.xbyte(op, 8, rx);
    mst.xbyte(a[7:0], 8, rx);
    if (wpp)
    begin
      wp_n = 1'b0;
      mst.tick(8);
      wp_n = 1'b1;
    end
    for (int i = 0; i < n; i++)
      mst.xbyte(b + 8'(i), 8, rx);
    mst.desel();
  endtask

  task automatic rd(input logic [8:0] a, input int n);
    logic [7:0] op;
    op = OP_ARRAY_READ;
    op[OP_X_BIT] = a[8];
    q.delete();
    mst.sel();
    mst.xbyte(op, 8, rx);
    mst.xbyte(a[7:0], 8, rx);
    for (int i = 0; i < n; i++)
    begin
      mst.xbyte(8'h00, 8, rx);
      q.push_back(rx);
    end
    mst.desel();
  endtask

  initial
  begin
    repeat (50000) @(posedge core_clk);
    errors++;
    end_sim();
  end

  initial
  begin
    core_clk = 1'b0;
    rst = 1'b1;
    wp_n = 1'b1;
    lvl = 2'b00;
    errors = 0;
    n_compared = 0;
    bnd = '{9'h000, 9'h180, 9'h100, 9'h000};
    repeat (6) @(posedge core_clk);
    #1;
    rst = 1'b0;
    mst.tick(20);
    `CHK("idle oe", 1'b0, so_oe)
    sr(8'hF0, 3);
    `CHK("oe paused", 1'b0, mst.oe_held)
    cmd(OP_ARM_WRITE);
    sr(8'hF2, 8);
    cmd(OP_DISARM_WRITE);
    sr(8'hF0, 8);
    // a write without arming must not start programming
    mst.sel();
    mst.xbyte(OP_ARRAY_WRITE, 8, rx);
    mst.xbyte(8'h00, 8, rx);
    mst.xbyte(8'h5A, 8, rx);
    mst.desel();
    sr(8'hF0, 8);
    wr(9'h1F0, 17, 8'h40, 1'b0);
    sr(8'hF3, 8);
    rd(9'h000, 1);
    `CHK("busy read oe", 1'b0, mst.oe_seen)
    wait_ready();
    wr(9'h000, 1, 8'hA5, 1'b0);
    wait_ready();
    mst.mode3 = 1'b1;
    rd(9'h1F0, 17);
    `CHK("read oe", 1'b1, mst.oe_seen)
    `CHK("desel oe", 1'b0, so_oe)
    mst.mode3 = 1'b0;
    for (int i = 0; i < 17; i++)
    begin
      e = (i == 16) ? 8'hA5 : (i == 0) ? 8'h50 : 8'h40 + 8'(i);
      `CHK("seq read", e, q[i])
    end
    wp_n = 1'b0;
    cmd(OP_ARM_WRITE);
    sr(8'hF0, 8);
    wp_n = 1'b1;
    wr(9'h000, 1, 8'h11, 1'b1);
    sr(8'hF0, 8);
    wr(9'h001, 1, 8'h77, 1'b0);
    wp_n = 1'b0;
    sr(8'hF1, 8);
    wp_n = 1'b1;
    wait_ready();
    rd(9'h000, 2);
    `CHK("guard drop", 8'hA5, q[0])
    `CHK("guard late", 8'h77, q[1])
    for (int l = 1; l < 4; l++)
    begin
      lvl = 2'(l);
      stw(lvl);
      wait_ready();
      wr(bnd[l], 1, 8'h33, 1'b0);
      sr({STATE_HI_ONES, lvl, 2'b10}, 8);
      if (l < 3)
      begin
        wr(bnd[l] - 9'h001, 1, 8'h99, 1'b0);
        sr({STATE_HI_ONES, lvl, 2'b11}, 8);
        wait_ready();
      end
    end
    lvl = 2'b00;
    stw(lvl);
    wait_ready();
    mst.sel();
    mst.xbyte(8'hFF, 8, rx);
    mst.xbyte(8'h00, 8, rx);
    mst.desel();
    `CHK("bad op oe", 1'b0, mst.oe_seen)
    end_sim();
  end
endmodule // test_spi_eeprom_command_slave
